/* File: common/btu_pkg.sv */
package btu_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LONG_OP_NS = 2000;
  localparam int SHORT_OP_NS = 1000;
  // Least times, so round up to whole cycles
  localparam int LONG_OP_CYC = (LONG_OP_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;
  localparam int SHORT_OP_CYC = (SHORT_OP_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int CNT_W = 5;

  // ---------------------------------------------------------------
  // Opcode encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h01;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_INDEXED_JUMP = 8'h03;
  localparam logic [7:0] OP_LONG_CALL = 8'h04;
  localparam logic [7:0] OP_SUB_RETURN = 8'h05;
  localparam logic [7:0] OP_INT_RETURN = 8'h06;
  localparam logic [7:0] OP_JUMP_ZERO = 8'h07;
  localparam logic [7:0] OP_JUMP_NONZERO = 8'h08;
  localparam logic [7:0] OP_DEC_BR_DIR = 8'h09;
  localparam logic [7:0] OP_DEC_BR_REG = 8'h0a;
  localparam logic [7:0] OP_CMP_ACC_DIR = 8'h0b;
  localparam logic [7:0] OP_CMP_ACC_IMM = 8'h0c;
  localparam logic [7:0] OP_CMP_IND_IMM = 8'h0d;
  localparam logic [7:0] OP_CMP_REG_IMM = 8'h0e;
  // Page forms: opcode bits 7..5 carry destination bits 10..8
  localparam logic [4:0] PAGE_JUMP_LOW = 5'h1e;
  localparam logic [4:0] PAGE_CALL_LOW = 5'h1f;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int PAGE_LSB = 11;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  typedef enum logic [1:0] {
    BTU_IDLE = 2'b00,
    BTU_EXEC = 2'b01
  } btu_state_t;

endpackage

/* File: hdl/btu_rel_add.sv */
`timescale 1ns/10ps
`default_nettype none

// Adds a signed 8-bit offset to a 16-bit address, wrapping at 64K
module btu_rel_add (
  input wire logic [15:0] base_in,
  input wire logic [7:0] offset_in,
  output logic [15:0] sum_out
);

  // Sign extension makes the byte act as -128..+127
  assign sum_out = base_in + {{8{offset_in[7]}}, offset_in};

endmodule

`default_nettype wire

/* File: hdl/btu_branch_unit.sv */
// Function
// - Relative offset is a signed byte added to the program counter.
// - Relative reach -128..+127 from the byte after the instruction.
// - Jumps, calls and returns take 2 us; no-operation takes 1 us.
// - Short jump is two bytes: opcode plus relative offset.
// - Long jump is three bytes with a 16-bit absolute destination.
// - Page jump is two bytes; opcode holds 3 of the 11 bits.
// - Page jump replaces low 11 counter bits, keeps the high 5.
// - Indexed jump goes to data pointer plus accumulator.
// - Long call takes 16-bit address; page call uses 11-bit format.
// - Subroutine return resumes after the call that entered it.
// - Interrupt return also signals interrupt end when one is active.
// - All conditional jumps use a relative offset destination.
// - Zero tests look at the accumulator directly, no flag.
// - Decrement-and-branch decrements, branches if result not zero.
// - Compare-and-branch branches only when its two bytes differ.
// - Compare is unsigned; carry set when first below second.
`timescale 1ns/10ps
`default_nettype none

module btu_branch_unit
  import btu_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] byte1_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] acc_in,
  input wire logic [15:0] data_pointer_in,
  input wire logic [7:0] opnd_in,
  input wire logic [15:0] ret_addr_in,
  input wire logic irq_active_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] pc_out,
  output logic taken_out,
  output logic push_out,
  output logic [15:0] push_addr_out,
  output logic pop_out,
  output logic irq_done_out,
  output logic dec_wr_out,
  output logic [7:0] dec_value_out,
  output logic carry_wr_out,
  output logic carry_out
);

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  logic [1:0] len;
  logic is_long, rel_br, abs_go, idx_go, page_go, ret_go, is_interrupt_return;
  logic do_push, do_dec, do_cmp, use_b2, cond;
  logic [7:0] cmp_a, cmp_b, dec_val, rel_byte;
  logic [15:0] pc_after, rel_sum, target;

  // Length, operand routing and condition for the presented opcode
  always_comb begin
    len = LEN_ONE;
    is_long = 1'b1;
    rel_br = 1'b0;
    abs_go = 1'b0;
    idx_go = 1'b0;
    page_go = 1'b0;
    ret_go = 1'b0;
    is_interrupt_return = 1'b0;
    do_push = 1'b0;
    do_dec = 1'b0;
    do_cmp = 1'b0;
    use_b2 = 1'b0;
    cond = 1'b0;
    cmp_a = acc_in;
    cmp_b = byte1_in;
    dec_val = opnd_in - 8'h01;
    case (opcode_in)
      OP_NOP: begin
        is_long = 1'b0;
      end
      OP_SHORT_JUMP: begin
        len = LEN_TWO;
        rel_br = 1'b1;
        cond = 1'b1;
      end
      OP_LONG_JUMP: begin
        len = LEN_THREE;
        abs_go = 1'b1;
      end
      OP_INDEXED_JUMP: begin
        idx_go = 1'b1;
      end
      OP_LONG_CALL: begin
        len = LEN_THREE;
        abs_go = 1'b1;
        do_push = 1'b1;
      end
      OP_SUB_RETURN: begin
        ret_go = 1'b1;
      end
      OP_INT_RETURN: begin
        ret_go = 1'b1;
        is_interrupt_return = 1'b1;
      end
      OP_JUMP_ZERO: begin
        len = LEN_TWO;
        rel_br = 1'b1;
        cond = (acc_in == 8'h00);
      end
      OP_JUMP_NONZERO: begin
        len = LEN_TWO;
        rel_br = 1'b1;
        cond = (acc_in != 8'h00);
      end
      OP_DEC_BR_DIR: begin
        len = LEN_THREE;
        rel_br = 1'b1;
        use_b2 = 1'b1;
        do_dec = 1'b1;
        cond = (dec_val != 8'h00);
      end
      OP_DEC_BR_REG: begin
        len = LEN_TWO;
        rel_br = 1'b1;
        do_dec = 1'b1;
        cond = (dec_val != 8'h00);
      end
      OP_CMP_ACC_DIR, OP_CMP_ACC_IMM,
      OP_CMP_IND_IMM, OP_CMP_REG_IMM: begin
        len = LEN_THREE;
        rel_br = 1'b1;
        use_b2 = 1'b1;
        do_cmp = 1'b1;
        if (opcode_in == OP_CMP_ACC_DIR) begin
          cmp_b = opnd_in;
        end else if (opcode_in != OP_CMP_ACC_IMM) begin
          cmp_a = opnd_in;
        end
        cond = (cmp_a != cmp_b);
      end
      default: begin
        // Page forms; anything unknown runs as a short no-operation
        if (opcode_in[4:0] == PAGE_JUMP_LOW) begin
          len = LEN_TWO;
          page_go = 1'b1;
        end else if (opcode_in[4:0] == PAGE_CALL_LOW) begin
          len = LEN_TWO;
          page_go = 1'b1;
          do_push = 1'b1;
        end else begin
          is_long = 1'b0;
        end
      end
    endcase
  end

  // Offset measured from the first byte after the instruction
  assign pc_after = pc_in + {14'h0000, len};
  assign rel_byte = use_b2 ? byte2_in : byte1_in;

  btu_rel_add u_rel_add (
    .base_in(pc_after),
    .offset_in(rel_byte),
    .sum_out(rel_sum)
  );

  // Destination selection
  always_comb begin
    if (rel_br && cond) begin
      target = rel_sum;
    end else if (abs_go) begin
      target = {byte1_in, byte2_in};
    end else if (idx_go) begin
      target = data_pointer_in + {8'h00, acc_in};
    end else if (page_go) begin
      // High 5 bits come from the address after the instruction
      target = {pc_after[15:PAGE_LSB], opcode_in[7:5], byte1_in};
    end else if (ret_go) begin
      target = ret_addr_in;
    end else begin
      target = pc_after;
    end
  end

  // -----------------------------------------------------------------
  // Sequencer and pending results
  // -----------------------------------------------------------------
  btu_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, last_cnt;
  logic take, commit;
  logic pend_long, next_pend_long;
  logic [15:0] pend_target, next_pend_target;
  logic [15:0] pend_link, next_pend_link;
  logic pend_taken, next_pend_taken;
  logic pend_push, next_pend_push;
  logic pend_pop, next_pend_pop;
  logic pend_irq, next_pend_irq;
  logic pend_dec, next_pend_dec;
  logic [7:0] pend_dec_val, next_pend_dec_val;
  logic pend_cmp, next_pend_cmp;
  logic pend_carry, next_pend_carry;

  assign busy_out = (state == BTU_EXEC);
  assign take = start_in && (state == BTU_IDLE);
  // Operands are caught at issue, so inputs may change while busy
  assign last_cnt = pend_long ? CNT_W'(LONG_OP_CYC - 1) :
                                CNT_W'(SHORT_OP_CYC - 1);
  assign commit = (state == BTU_EXEC) && (cnt == last_cnt);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pend_long = pend_long;
    next_pend_target = pend_target;
    next_pend_link = pend_link;
    next_pend_taken = pend_taken;
    next_pend_push = pend_push;
    next_pend_pop = pend_pop;
    next_pend_irq = pend_irq;
    next_pend_dec = pend_dec;
    next_pend_dec_val = pend_dec_val;
    next_pend_cmp = pend_cmp;
    next_pend_carry = pend_carry;
    case (state)
      BTU_IDLE: begin
        if (take) begin
          next_state = BTU_EXEC;
          next_cnt = '0;
          next_pend_long = is_long;
          next_pend_target = target;
          next_pend_link = pc_after;
          next_pend_taken = (rel_br && cond) || abs_go || idx_go ||
                            page_go || ret_go;
          next_pend_push = do_push;
          next_pend_pop = ret_go;
          next_pend_irq = is_interrupt_return && irq_active_in;
          next_pend_dec = do_dec;
          next_pend_dec_val = dec_val;
          next_pend_cmp = do_cmp;
          next_pend_carry = (cmp_a < cmp_b);
        end
      end
      BTU_EXEC: begin
        if (commit) begin
          next_state = BTU_IDLE;
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      default: begin
        next_state = BTU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= BTU_IDLE;
      cnt <= '0;
      pend_long <= 1'b0;
      pend_target <= PC_RESET;
      pend_link <= PC_RESET;
      pend_taken <= 1'b0;
      pend_push <= 1'b0;
      pend_pop <= 1'b0;
      pend_irq <= 1'b0;
      pend_dec <= 1'b0;
      pend_dec_val <= 8'h00;
      pend_cmp <= 1'b0;
      pend_carry <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pend_long <= next_pend_long;
      pend_target <= next_pend_target;
      pend_link <= next_pend_link;
      pend_taken <= next_pend_taken;
      pend_push <= next_pend_push;
      pend_pop <= next_pend_pop;
      pend_irq <= next_pend_irq;
      pend_dec <= next_pend_dec;
      pend_dec_val <= next_pend_dec_val;
      pend_cmp <= next_pend_cmp;
      pend_carry <= next_pend_carry;
    end
  end

  // -----------------------------------------------------------------
  // Outputs: all side effects land together at commit
  // -----------------------------------------------------------------
  logic [15:0] next_pc, next_push_addr;
  logic [7:0] next_dec_value;
  logic next_taken, next_carry;

  always_comb begin
    next_pc = commit ? pend_target : pc_out;
    next_taken = commit ? pend_taken : taken_out;
    next_push_addr = (commit && pend_push) ? pend_link : push_addr_out;
    next_dec_value = (commit && pend_dec) ? pend_dec_val : dec_value_out;
    next_carry = (commit && pend_cmp) ? pend_carry : carry_out;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_out <= PC_RESET;
      done_out <= 1'b0;
      taken_out <= 1'b0;
      push_out <= 1'b0;
      push_addr_out <= PC_RESET;
      pop_out <= 1'b0;
      irq_done_out <= 1'b0;
      dec_wr_out <= 1'b0;
      dec_value_out <= 8'h00;
      carry_wr_out <= 1'b0;
      carry_out <= 1'b0;
    end else begin
      pc_out <= next_pc;
      done_out <= commit;
      taken_out <= next_taken;
      push_out <= commit && pend_push;
      push_addr_out <= next_push_addr;
      pop_out <= commit && pend_pop;
      irq_done_out <= commit && pend_irq;
      dec_wr_out <= commit && pend_dec;
      dec_value_out <= next_dec_value;
      carry_wr_out <= commit && pend_cmp;
      carry_out <= next_carry;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic [15:0] sext_b1, sext_b2, pc_plus2, pc_plus3, idx_sum;
  assign sext_b1 = {{8{byte1_in[7]}}, byte1_in};
  assign sext_b2 = {{8{byte2_in[7]}}, byte2_in};
  assign pc_plus2 = pc_in + 16'h0002;
  assign pc_plus3 = pc_in + 16'h0003;
  assign idx_sum = data_pointer_in + {8'h00, acc_in};

  sequence s_take(logic [7:0] op);
    start_in && !busy_out && opcode_in == op;
  endsequence

  // Pulse registers on the edge after the last counted cycle, edge k+20, and is sampled at edge k+21
  sequence s_done_long;
    !done_out [*8] ##13 done_out;
  endsequence

  rel_jump_a: assert property (s_take(OP_SHORT_JUMP) |-> ##21
    done_out && pc_out == $past(pc_plus2, 21) + $past(sext_b1, 21))
    else $error("short jump target wrong");
  jump_time_a: assert property (s_take(OP_LONG_JUMP) |->
    ##1 s_done_long) else $error("long op not 2 us");
  nop_time_a: assert property (s_take(OP_NOP) |->
    ##1 !done_out [*8] ##3 done_out) else $error("nop not 1 us");
  long_jump_a: assert property (s_take(OP_LONG_JUMP) |-> ##21
    pc_out == {$past(byte1_in, 21), $past(byte2_in, 21)})
    else $error("long jump target wrong");
  page_jump_a: assert property (start_in && !busy_out &&
    opcode_in[4:0] == PAGE_JUMP_LOW |-> ##21 pc_out ==
    {$past(pc_plus2[15:11], 21), $past(opcode_in[7:5], 21),
     $past(byte1_in, 21)}) else $error("page jump target wrong");
  index_jump_a: assert property (s_take(OP_INDEXED_JUMP) |-> ##21
    pc_out == $past(idx_sum, 21)) else $error("indexed jump wrong");
  call_link_a: assert property (s_take(OP_LONG_CALL) |-> ##21
    push_out && push_addr_out == $past(pc_plus3, 21))
    else $error("call link address wrong");
  ret_target_a: assert property (s_take(OP_SUB_RETURN) |-> ##21
    pop_out && !irq_done_out && pc_out == $past(ret_addr_in, 21))
    else $error("return target wrong");
  interrupt_return_notify_a: assert property (s_take(OP_INT_RETURN) |-> ##21
    pop_out && irq_done_out == $past(irq_active_in, 21))
    else $error("interrupt return signal wrong");
  zero_test_a: assert property (s_take(OP_JUMP_ZERO) |-> ##21
    taken_out == ($past(acc_in, 21) == 8'h00))
    else $error("zero test wrong");
  dec_branch_a: assert property (s_take(OP_DEC_BR_DIR) |-> ##21
    dec_wr_out && dec_value_out == $past(opnd_in, 21) - 8'h01 &&
    taken_out == ($past(opnd_in, 21) != 8'h01))
    else $error("decrement branch wrong");
  cmp_carry_a: assert property (s_take(OP_CMP_ACC_IMM) |-> ##21
    carry_wr_out && carry_out == ($past(acc_in, 21) < $past(byte1_in, 21))
    && taken_out == ($past(acc_in, 21) != $past(byte1_in, 21)))
    else $error("compare carry wrong");
  not_taken_a: assert property (s_take(OP_CMP_REG_IMM) ##0
    opnd_in == byte1_in |-> ##21 !taken_out &&
    pc_out == $past(pc_plus3, 21)) else $error("fall-through wrong");
  cond_rel_a: assert property (s_take(OP_DEC_BR_REG) ##0
    opnd_in != 8'h01 |-> ##21 pc_out == $past(pc_plus2, 21) +
    $past(sext_b1, 21)) else $error("conditional offset wrong");
  cmp_dir_a: assert property (s_take(OP_CMP_ACC_DIR) ##0
    acc_in != opnd_in |-> ##21 pc_out == $past(pc_plus3, 21) +
    $past(sext_b2, 21)) else $error("compare branch wrong");

endmodule

`default_nettype wire

/* File: verif/tb_branch_target_unit.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_branch_target_unit;
  import btu_pkg::*;

  // ---------------------------------------------
  // Stimulus, outputs and bookkeeping
  // ---------------------------------------------
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0;
  logic irq_active_in = 1'b0;
  logic [7:0] opcode_in = 8'h00, byte1_in = 8'h00, byte2_in = 8'h00;
  logic [7:0] acc_in = 8'h00, opnd_in = 8'h00;
  logic [15:0] pc_in = 16'h0000, data_pointer_in = 16'h0000;
  logic [15:0] ret_addr_in = 16'h0000;
  logic busy_out, done_out, taken_out, push_out, pop_out, irq_done_out;
  logic dec_wr_out, carry_wr_out, carry_out;
  logic [15:0] pc_out, push_addr_out;
  logic [7:0] dec_value_out, cur_op;
  int fails = 0;
  int comparisons = 0;
  logic [15:0] lfsr = 16'h0013;
  // Expected results of the operation in flight
  logic [15:0] e_pc, e_paddr, e_n;
  logic [7:0] e_dval;
  logic e_taken, e_chk_taken, e_push, e_pop, e_irq, e_dwr, e_cwr, e_carry;

  // Clock inverts every half period of 100 ns
  always #50 clk_in = ~clk_in;

  btu_branch_unit dut (.clk_in(clk_in), .rst_in(rst_in),
    .start_in(start_in), .pc_in(pc_in), .opcode_in(opcode_in),
    .byte1_in(byte1_in), .byte2_in(byte2_in), .acc_in(acc_in),
    .data_pointer_in(data_pointer_in), .opnd_in(opnd_in), .ret_addr_in(ret_addr_in),
    .irq_active_in(irq_active_in), .busy_out(busy_out),
    .done_out(done_out), .pc_out(pc_out), .taken_out(taken_out),
    .push_out(push_out), .push_addr_out(push_addr_out), .pop_out(pop_out),
    .irq_done_out(irq_done_out), .dec_wr_out(dec_wr_out),
    .dec_value_out(dec_value_out), .carry_wr_out(carry_wr_out),
    .carry_out(carry_out));

  // ---------------------------------------------
  // Random source and reference model
  // ---------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Relative forms add the signed byte to the address after the instruction bytes
  function automatic void predict(input logic [7:0] op, b1, b2, acc, opnd,
      input logic [15:0] pc, data_pointer, ra, input logic irq);
    logic [1:0] len;
    logic [7:0] rel, first, second, dec;
    logic [15:0] seq, tgt;
    logic br, cond, generic_jump;
    len = LEN_ONE;
    rel = b1;
    {br, cond, generic_jump} = 3'h0;
    tgt = 16'h0000;
    dec = opnd - 8'h01;
    e_n = 16'h0014;
    e_chk_taken = 1'b1;
    {e_taken, e_push, e_pop, e_irq, e_dwr, e_cwr, e_carry} = 7'h00;
    e_dval = dec;
    if (op[4:0] == PAGE_JUMP_LOW || op[4:0] == PAGE_CALL_LOW) begin
      len = LEN_TWO;
      generic_jump = 1'b1;
      e_taken = 1'b1;
      e_push = (op[4:0] == PAGE_CALL_LOW);
      e_chk_taken = ~e_push;
      tgt = {pc[15:11] + ((pc[10:0] + 11'h002) < 11'h002 ? 5'h01 : 5'h00),
             op[7:5], b1};
    end else begin
      case (op)
        OP_NOP: e_n = 16'h000a;
        OP_SHORT_JUMP: begin
          len = LEN_TWO;
          {br, cond} = 2'h3;
        end
        OP_LONG_JUMP, OP_LONG_CALL: begin
          len = LEN_THREE;
          generic_jump = 1'b1;
          tgt = {b1, b2};
          e_taken = 1'b1;
          e_push = (op == OP_LONG_CALL);
          e_chk_taken = ~e_push;
        end
        OP_INDEXED_JUMP: begin
          {generic_jump, e_taken} = 2'h3;
          tgt = data_pointer + {8'h00, acc};
        end
        OP_SUB_RETURN, OP_INT_RETURN: begin
          {generic_jump, e_pop, e_chk_taken} = 3'h6;
          tgt = ra;
          e_irq = (op == OP_INT_RETURN) & irq;
        end
        OP_JUMP_ZERO, OP_JUMP_NONZERO: begin
          len = LEN_TWO;
          br = 1'b1;
          cond = (acc == 8'h00) ^ (op == OP_JUMP_NONZERO);
        end
        OP_DEC_BR_DIR, OP_DEC_BR_REG: begin
          len = (op == OP_DEC_BR_DIR) ? LEN_THREE : LEN_TWO;
          rel = (op == OP_DEC_BR_DIR) ? b2 : b1;
          {br, e_dwr} = 2'h3;
          cond = (dec != 8'h00);
        end
        default: begin
          if (op >= OP_CMP_ACC_DIR && op <= OP_CMP_REG_IMM) begin
            len = LEN_THREE;
            rel = b2;
            {br, e_cwr} = 2'h3;
            first = (op >= OP_CMP_IND_IMM) ? opnd : acc;
            second = (op == OP_CMP_ACC_DIR) ? opnd : b1;
            cond = (first != second);
            e_carry = (first < second);
          end else begin
            e_n = 16'h000a;
          end
        end
      endcase
    end
    seq = pc + {14'h0000, len};
    if (br) begin
      e_taken = cond;
      tgt = seq + {{8{rel[7]}}, rel};
    end
    e_pc = (br ? cond : generic_jump) ? tgt : seq;
    e_paddr = seq;
  endfunction

  // ---------------------------------------------
  // Compare tasks and verdict
  // ---------------------------------------------
  task automatic cmp_word(input logic [15:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h op %h", $time, what, got, exp,
               cur_op);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, exp, input string what);
    cmp_word({8'h00, got}, {8'h00, exp}, what);
  endtask

  task automatic cmp_bit(input logic got, exp, input string what);
    cmp_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Drivers
  // ---------------------------------------------
  // Junk while busy: a late request must be ignored, inputs only count at take
  task automatic scramble();
    logic [15:0] r;
    r = rnd();
    start_in <= r[0];
    opcode_in <= r[15:8];
    byte1_in <= r[7:0];
    byte2_in <= r[11:4];
    acc_in <= r[9:2];
    opnd_in <= r[14:7];
    irq_active_in <= r[3];
    pc_in <= rnd();
    data_pointer_in <= rnd();
    ret_addr_in <= rnd();
  endtask

  task automatic run_op(input logic [7:0] op, b1, b2, acc, opnd,
      input logic [15:0] pc, data_pointer, ra, input logic irq);
    int cnt;
    logic busy_ok;
    predict(op, b1, b2, acc, opnd, pc, data_pointer, ra, irq);
    cur_op = op;
    cnt = 0;
    busy_ok = 1'b1;
    @(posedge clk_in);
    start_in <= 1'b1;
    opcode_in <= op;
    byte1_in <= b1;
    byte2_in <= b2;
    acc_in <= acc;
    opnd_in <= opnd;
    pc_in <= pc;
    data_pointer_in <= data_pointer;
    ret_addr_in <= ra;
    irq_active_in <= irq;
    @(posedge clk_in);
    scramble();
    while (cnt < 40) begin
      @(posedge clk_in);
      cnt++;
      if (cnt < e_n) begin
        scramble();
      end else begin
        start_in <= 1'b0;
      end
      #1;
      if (done_out === 1'b1) break;
      busy_ok &= (busy_out === 1'b1);
    end
    cmp_word(16'(cnt), e_n, "cycles");
    cmp_bit(busy_ok, 1'b1, "busy");
    cmp_word(pc_out, e_pc, "pc");
    if (e_chk_taken) cmp_bit(taken_out, e_taken, "taken");
    cmp_bit(push_out, e_push, "push");
    if (e_push) cmp_word(push_addr_out, e_paddr, "link");
    cmp_bit(pop_out, e_pop, "pop");
    cmp_bit(irq_done_out, e_irq, "irq end");
    cmp_bit(dec_wr_out, e_dwr, "dec write");
    if (e_dwr) cmp_byte(dec_value_out, e_dval, "dec value");
    cmp_bit(carry_wr_out, e_cwr, "carry write");
    if (e_cwr) cmp_bit(carry_out, e_carry, "carry");
    $display("test op %h ended at %0t", op, $time);
  endtask

  // Corner case with random pointer, return address and interrupt state
  task automatic cc(input logic [7:0] op, b1, b2, acc, opnd,
      input logic [15:0] pc);
    logic [15:0] r;
    r = rnd();
    run_op(op, b1, b2, acc, opnd, pc, rnd(), r, r[0]);
  endtask

  task automatic check_reset();
    cmp_word(pc_out, PC_RESET, "reset pc");
    cmp_bit(busy_out, 1'b0, "reset busy");
    cmp_bit(done_out, 1'b0, "reset done");
  endtask

  // ---------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------
  initial begin
    logic [15:0] o;
    repeat (8) @(posedge clk_in);
    #1;
    check_reset();
    @(posedge clk_in);
    rst_in <= 1'b0;
    cc(OP_SHORT_JUMP, 8'h80, 8'h00, 8'h00, 8'h00, 16'h0100);
    cc(OP_SHORT_JUMP, 8'h7f, 8'h00, 8'h00, 8'h00, 16'hfffe);
    cc(OP_LONG_JUMP, 8'hab, 8'hcd, 8'h00, 8'h00, 16'h1234);
    cc(8'he0 | 8'h1e, 8'h55, 8'h00, 8'h00, 8'h00, 16'h07fe);
    cc(8'h3f, 8'h10, 8'h00, 8'h00, 8'h00, 16'h8000);
    cc(OP_LONG_CALL, 8'hff, 8'h00, 8'h00, 8'h00, 16'hfffd);
    run_op(OP_INDEXED_JUMP, 8'h00, 8'h00, 8'hff, 8'h00, 16'h0200,
           16'hff80, 16'h0000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run_op(i[1] ? OP_INT_RETURN : OP_SUB_RETURN, 8'h00, 8'h00, 8'h00,
             8'h00, 16'h0300, 16'h0000, 16'h4321, i[0]);
    end
    cc(OP_JUMP_ZERO, 8'hf0, 8'h00, 8'h00, 8'h00, 16'h0400);
    cc(OP_JUMP_ZERO, 8'hf0, 8'h00, 8'h01, 8'h00, 16'h0400);
    cc(OP_JUMP_NONZERO, 8'h10, 8'h00, 8'h00, 8'h00, 16'h0400);
    cc(OP_JUMP_NONZERO, 8'h10, 8'h00, 8'h80, 8'h00, 16'h0400);
    cc(OP_DEC_BR_REG, 8'hfe, 8'h00, 8'h00, 8'h01, 16'h0500);
    cc(OP_DEC_BR_REG, 8'hfe, 8'h00, 8'h00, 8'h00, 16'h0500);
    cc(OP_DEC_BR_DIR, 8'h33, 8'h81, 8'h00, 8'h02, 16'h0500);
    cc(OP_CMP_ACC_DIR, 8'h00, 8'h20, 8'h05, 8'h05, 16'h0600);
    cc(OP_CMP_ACC_IMM, 8'hfe, 8'h20, 8'h03, 8'h00, 16'h0600);
    cc(OP_CMP_IND_IMM, 8'h00, 8'he0, 8'h00, 8'hff, 16'h0600);
    cc(OP_CMP_REG_IMM, 8'h80, 8'h20, 8'h00, 8'h7f, 16'h0600);
    cc(OP_CMP_REG_IMM, 8'h7f, 8'h20, 8'h00, 8'h7f, 16'h0600);
    cc(OP_CMP_ACC_DIR, 8'h00, 8'h20, 8'h04, 8'h05, 16'h0600);
    cc(OP_NOP, 8'h00, 8'h00, 8'h00, 8'h00, 16'hffff);
    cc(8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0700);
    // Reset in mid-operation must abandon it cleanly
    @(posedge clk_in);
    opcode_in <= OP_LONG_JUMP;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b1;
    #1;
    check_reset();
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      o = rnd();
      run_op(o[8] ? o[7:0] : {4'h0, o[3:0]}, o[15:8], o[11:4], o[7:0],
             o[13:6], rnd(), rnd(), rnd(), o[2]);
    end
    print_verdict();
  end

  // About 1,300 to 1,900 cycles expected; cut off well beyond
  initial begin
    #(10000 * 100);
    fails++;
    print_verdict();
  end

endmodule

`default_nettype wire
